// ==== csd_defines.svh ====
// Purpose: Constants for the calibration and scaling datapath
// Assumes: Two channels, 16-bit samples, 50 MHz module clock
// Notes:   Offsets are object indexes, kept as printed
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH

`define CSD_NUM_CH          2
`define CSD_FIFO_DEPTH      8
`define CSD_FIFO_AW         3
`define CSD_RESTORE_IDX     16'h1011
`define CSD_RESTORE_SUB_CNT 8'h00
`define CSD_RESTORE_SUB_KEY 8'h01
`define CSD_RESTORE_CNT_RST 8'h01
`define CSD_RESTORE_KEY     32'h64616f6c
`define CSD_SET_IDX_BASE    16'h8010
`define CSD_VEND_IDX_BASE   16'h801f
`define CSD_IDX_CH_STEP     16'h0010
`define CSD_RAW_IDX_BASE    16'h801e
`define CSD_SUB_US_EN       8'h01
`define CSD_SUB_UC_EN       8'h07
`define CSD_SUB_VC_EN       8'h08
`define CSD_SUB_US_OFS      8'h11
`define CSD_SUB_US_GAIN     8'h12
`define CSD_SUB_UC_OFS      8'h15
`define CSD_SUB_UC_GAIN     8'h16
`define CSD_SUB_VC_OFS      8'h01
`define CSD_SUB_VC_GAIN     8'h02
`define CSD_SUB_RAW         8'h01
`define CSD_CAL_SHIFT       14
`define CSD_SCL_SHIFT       16
`define CSD_US_GAIN_RST     32'h00010000
`define CSD_UC_GAIN_RST     16'hffff
`define CSD_VC_GAIN_RST     16'h4000
`define CSD_OFS_RST         16'h0000
`define CSD_VC_EN_RST       1'b1
`define CSD_PRODUCER_KEY    32'h00000000

`endif

// ==== csd_fifo.sv ====
// Purpose: Sample FIFO in front of the correction chain
// Assumes: Same clock on both sides
// Notes:   Full and empty are exact; write ignored when full
`timescale 1ns/1ps
module csd_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   wire              push = i_in_valid && o_in_ready;
   wire              pop  = o_out_valid && i_out_ready;

   // Flags derived from the occupancy count
   assign o_in_ready  = (count_ff != (AW+1)'(DEPTH));
   assign o_out_valid = (count_ff != '0);
   assign o_out_data  = mem[rd_ptr_ff];

   // Storage, no reset needed for data
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_ff] <= i_in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
         if (pop)  rd_ptr_ff <= rd_ptr_ff + 1'b1;
         count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ==== csd_od_master.sv ====
// Purpose: Controller model reading and writing dictionary objects
// Assumes: Strobes are one-cycle pulses answered by an ack pulse
// Notes:   Idle lines carry inverted values so stale data is never trusted
`timescale 1ns/1ps
module csd_od_master (
   input  wire logic               i_clk,
   input  wire logic               i_ack,
   input  wire logic               i_err,
   input  wire csd_pkg::csd_word_t i_rdata,
   output logic                    o_wr,
   output logic                    o_rd,
   output csd_pkg::csd_index_t     o_index,
   output csd_pkg::csd_sub_t       o_sub,
   output csd_pkg::csd_word_t      o_wdata
);
   import csd_pkg::*;
   initial begin
      o_wr    = 1'b0;
      o_rd    = 1'b0;
      o_index = 16'h0000;
      o_sub   = 8'h00;
      o_wdata = 32'h00000000;
   end
   // One access; gap idles first so both prompt and slow controllers appear
   task automatic od_xfer(input logic wr, input csd_index_t idx, input csd_sub_t sub, input csd_word_t wd,
                          input int gap, output csd_word_t rd, output logic err);
      int n;
      repeat (gap + 1) @(posedge i_clk);
      #1;
      o_wr    = wr;
      o_rd    = !wr;
      o_index = idx;
      o_sub   = sub;
      o_wdata = wd;
      @(posedge i_clk);
      #1;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
      o_index = ~idx;
      o_sub   = ~sub;
      o_wdata = ~wd;
      n = 0;
      while (i_ack !== 1'b1 && n < 8) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      rd  = i_rdata;
      err = (i_ack === 1'b1) ? i_err : 1'b1;
   endtask
endmodule

// ==== csd_pkg.sv ====
// Purpose: Types for the calibration and scaling datapath
// Assumes: csd_defines.svh holds the numbers
// Notes:   Types only
package csd_pkg;
   typedef logic signed [15:0] csd_sample_t;
   typedef logic [15:0]        csd_index_t;
   typedef logic [7:0]         csd_sub_t;
   typedef logic [31:0]        csd_word_t;
   typedef enum logic [3:0] {
      CSD_IDLE = 4'b0001,
      CSD_VEND = 4'b0010,
      CSD_USER = 4'b0100,
      CSD_SCAL = 4'b1000
   } csd_state_t;
endpackage

// ==== csd_top.sv ====
// Purpose: Per-channel calibration and scaling of raw converter samples
// Assumes: Object dictionary writes arrive as index/subindex/data strobes
// Notes:   One stage per clock, result saturated to 16 bits
//          Ready is exact, so an obeying sender never loses a sample
`timescale 1ns/1ps
`include "csd_defines.svh"
module csd_top (
   input  wire logic             I_REF_CLK,
   input  wire logic             I_RST_N,
   input  wire logic             I_RAW_VALID,
   output logic                  O_RAW_READY,
   input  wire logic             I_RAW_CH,
   input  wire csd_pkg::csd_sample_t I_RAW_DATA,
   input  wire logic             I_OD_WR,
   input  wire logic             I_OD_RD,
   input  wire csd_pkg::csd_index_t I_OD_INDEX,
   input  wire csd_pkg::csd_sub_t   I_OD_SUB,
   input  wire csd_pkg::csd_word_t  I_OD_WDATA,
   output csd_pkg::csd_word_t       O_OD_RDATA,
   output logic                  O_OD_ACK,
   output logic                  O_OD_ERR,
   output logic                  O_PV_VALID,
   output logic                  O_PV_CH,
   output csd_pkg::csd_sample_t  O_PV_DATA
);
   import csd_pkg::*;

   // -----------------------------------------------------------------
   // Functions
   // -----------------------------------------------------------------
   // Clamp a wide signed value into the 16-bit range
   // Clamping beats wrapping, which would swing the output end to end
   function automatic csd_sample_t sat16(input logic signed [63:0] v);
      if (v > 64'sd32767)       sat16 = 16'sh7fff;
      else if (v < -64'sd32768) sat16 = 16'sh8000;
      else                      sat16 = v[15:0];
   endfunction

   // Calibration step, gain taken unsigned in Q2.14
   function automatic csd_sample_t cal_step(input csd_sample_t x, input csd_sample_t ofs,
                                            input logic [15:0] gain);
      logic signed [63:0] d;
      d = 64'(x) - 64'(ofs);
      cal_step = sat16((d * $signed({48'h0, gain})) >>> `CSD_CAL_SHIFT);
   endfunction

   // Object index for a channel
   function automatic csd_index_t ch_idx(input csd_index_t base, input logic ch);
      ch_idx = base + (ch ? `CSD_IDX_CH_STEP : 16'h0000);
   endfunction

   // -----------------------------------------------------------------
   // Parameter storage
   // -----------------------------------------------------------------
   logic        us_en_ff  [2];
   logic        uc_en_ff  [2];
   logic        vc_en_ff  [2];
   csd_sample_t us_ofs_ff [2];
   csd_word_t   us_gain_ff[2];
   csd_sample_t uc_ofs_ff [2];
   logic [15:0] uc_gain_ff[2];
   csd_sample_t vc_ofs_ff [2];
   logic [15:0] vc_gain_ff[2];
   csd_sample_t raw_ff    [2];
   // Key words written by the controller
   csd_word_t   restore_key_ff;
   csd_word_t   producer_key_ff;

   // Vendor coefficients only open once the producer key is stored
   // A zero key macro keeps them locked, as delivered
   wire         key_ok  = (producer_key_ff == `CSD_PRODUCER_KEY) && (`CSD_PRODUCER_KEY != 32'h0);
   wire         restore = I_OD_WR && (I_OD_INDEX == `CSD_RESTORE_IDX)
                          && (I_OD_SUB == `CSD_RESTORE_SUB_KEY) && (I_OD_WDATA == `CSD_RESTORE_KEY);

   // Per-channel address hits
   logic set_hit [2];
   logic vnd_hit [2];
   logic raw_hit [2];
   for (genvar c = 0; c < 2; c++) begin : g_hit
      assign set_hit[c] = (I_OD_INDEX == ch_idx(`CSD_SET_IDX_BASE, (c != 0)));
      assign vnd_hit[c] = (I_OD_INDEX == ch_idx(`CSD_VEND_IDX_BASE, (c != 0)));
      assign raw_hit[c] = (I_OD_INDEX == ch_idx(`CSD_RAW_IDX_BASE, (c != 0)));
   end

   // Settings per channel; restore brings back delivery values
   // Restore leaves vendor coefficients alone: they belong to the maker
   for (genvar c = 0; c < 2; c++) begin : g_par
      always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
         if (!I_RST_N) begin
            us_en_ff[c]   <= 1'b0;
            uc_en_ff[c]   <= 1'b0;
            vc_en_ff[c]   <= `CSD_VC_EN_RST;
            us_ofs_ff[c]  <= `CSD_OFS_RST;
            us_gain_ff[c] <= `CSD_US_GAIN_RST;
            uc_ofs_ff[c]  <= `CSD_OFS_RST;
            uc_gain_ff[c] <= `CSD_UC_GAIN_RST;
            vc_ofs_ff[c]  <= `CSD_OFS_RST;
            vc_gain_ff[c] <= `CSD_VC_GAIN_RST;
         end else if (restore) begin
            us_en_ff[c]   <= 1'b0;
            uc_en_ff[c]   <= 1'b0;
            vc_en_ff[c]   <= `CSD_VC_EN_RST;
            us_ofs_ff[c]  <= `CSD_OFS_RST;
            us_gain_ff[c] <= `CSD_US_GAIN_RST;
            uc_ofs_ff[c]  <= `CSD_OFS_RST;
            uc_gain_ff[c] <= `CSD_UC_GAIN_RST;
         end else if (I_OD_WR && set_hit[c]) begin
            if (I_OD_SUB == `CSD_SUB_US_EN)   us_en_ff[c]   <= I_OD_WDATA[0];
            if (I_OD_SUB == `CSD_SUB_UC_EN)   uc_en_ff[c]   <= I_OD_WDATA[0];
            if (I_OD_SUB == `CSD_SUB_VC_EN)   vc_en_ff[c]   <= I_OD_WDATA[0];
            if (I_OD_SUB == `CSD_SUB_US_OFS)  us_ofs_ff[c]  <= I_OD_WDATA[15:0];
            if (I_OD_SUB == `CSD_SUB_US_GAIN) us_gain_ff[c] <= I_OD_WDATA;
            if (I_OD_SUB == `CSD_SUB_UC_OFS)  uc_ofs_ff[c]  <= I_OD_WDATA[15:0];
            if (I_OD_SUB == `CSD_SUB_UC_GAIN) uc_gain_ff[c] <= I_OD_WDATA[15:0];
         end else if (I_OD_WR && vnd_hit[c] && key_ok) begin
            if (I_OD_SUB == `CSD_SUB_VC_OFS)  vc_ofs_ff[c]  <= I_OD_WDATA[15:0];
            if (I_OD_SUB == `CSD_SUB_VC_GAIN) vc_gain_ff[c] <= I_OD_WDATA[15:0];
         end
      end
   end

   // Key registers; restore key reads back zero after acting
   wire         key_wr = I_OD_WR && (I_OD_INDEX == `CSD_RESTORE_IDX) && (I_OD_SUB == `CSD_RESTORE_SUB_KEY);
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         restore_key_ff  <= 32'h0;
         producer_key_ff <= 32'h0;
      end else begin
         if (restore) begin
            restore_key_ff <= 32'h0;
         end else if (key_wr) begin
            restore_key_ff <= I_OD_WDATA;
         end
         if (I_OD_WR && vnd_hit[0] && (I_OD_SUB == 8'h00)) producer_key_ff <= I_OD_WDATA;
      end
   end

   // -----------------------------------------------------------------
   // Sample FIFO
   // -----------------------------------------------------------------
   // Pop only while idle: the stages share one accumulator
   csd_state_t  state_ff;
   logic        f_valid;
   logic        f_ready;
   logic [16:0] f_data;
   wire         f_pop_ok = (state_ff == CSD_IDLE);

   csd_fifo #(.WIDTH(17), .DEPTH(`CSD_FIFO_DEPTH), .AW(`CSD_FIFO_AW)) u_fifo (
      .i_clk       (I_REF_CLK),
      .i_rst_n     (I_RST_N),
      .i_in_valid  (I_RAW_VALID),
      .o_in_ready  (f_ready),
      .i_in_data   ({I_RAW_CH, I_RAW_DATA}),
      .o_out_valid (f_valid),
      .i_out_ready (f_pop_ok),
      .o_out_data  (f_data)
   );

   // -----------------------------------------------------------------
   // Correction chain
   // -----------------------------------------------------------------
   csd_state_t  nxt_state;
   csd_sample_t acc_ff;
   csd_sample_t nxt_acc;
   logic        ch_ff;
   wire         take = f_valid && (state_ff == CSD_IDLE);
   // All three stage results are formed every cycle; the state picks one
   wire  csd_sample_t vend_val = cal_step(acc_ff, vc_ofs_ff[ch_ff], vc_gain_ff[ch_ff]);
   wire  csd_sample_t user_val = cal_step(acc_ff, uc_ofs_ff[ch_ff], uc_gain_ff[ch_ff]);
   wire  logic signed [63:0] scl_prod = (64'(acc_ff) * 64'($signed(us_gain_ff[ch_ff]))) >>> `CSD_SCL_SHIFT;
   wire  csd_sample_t scal_val = sat16(scl_prod + 64'(us_ofs_ff[ch_ff]));

   // Step through the three stages, each optional
   // One stage per clock keeps each multiplier path short
   always_comb begin
      nxt_state = state_ff;
      nxt_acc   = acc_ff;
      unique case (state_ff)
         CSD_IDLE: begin
            if (take) begin
               nxt_state = CSD_VEND;
               nxt_acc   = f_data[15:0];
            end
         end
         CSD_VEND: begin
            nxt_state = CSD_USER;
            if (vc_en_ff[ch_ff]) nxt_acc = vend_val;
         end
         CSD_USER: begin
            nxt_state = CSD_SCAL;
            if (uc_en_ff[ch_ff]) nxt_acc = user_val;
         end
         CSD_SCAL: begin
            nxt_state = CSD_IDLE;
            if (us_en_ff[ch_ff]) nxt_acc = scal_val;
         end
         default: begin
            nxt_state = CSD_IDLE;
         end
      endcase
   end

   // Chain registers, raw store and process value output
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state_ff   <= CSD_IDLE;
         acc_ff     <= 16'sh0000;
         ch_ff      <= 1'b0;
         raw_ff[0]  <= 16'sh0000;
         raw_ff[1]  <= 16'sh0000;
         O_PV_VALID <= 1'b0;
         O_PV_CH    <= 1'b0;
         O_PV_DATA  <= 16'sh0000;
      end else begin
         state_ff   <= nxt_state;
         acc_ff     <= nxt_acc;
         if (take) begin
            ch_ff             <= f_data[16];
            raw_ff[f_data[16]] <= f_data[15:0];
         end
         // Result data holds between results; only valid pulses
         O_PV_VALID <= (state_ff == CSD_SCAL);
         if (state_ff == CSD_SCAL) begin
            O_PV_CH   <= ch_ff;
            O_PV_DATA <= nxt_acc;
         end
      end
   end

   // -----------------------------------------------------------------
   // Object read port
   // -----------------------------------------------------------------
   logic        rd_hit;
   csd_word_t   rd_val;
   // Unknown objects read as zero with the error flag raised
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0;
      if (I_OD_INDEX == `CSD_RESTORE_IDX && I_OD_SUB == `CSD_RESTORE_SUB_CNT) rd_val = 32'(`CSD_RESTORE_CNT_RST);
      else if (I_OD_INDEX == `CSD_RESTORE_IDX && I_OD_SUB == `CSD_RESTORE_SUB_KEY) rd_val = restore_key_ff;
      else begin
         rd_hit = 1'b0;
         for (int c = 0; c < 2; c++) begin
            if (raw_hit[c] && I_OD_SUB == `CSD_SUB_RAW) begin
               rd_hit = 1'b1; rd_val = 32'(signed'(raw_ff[c]));
            end
            if (set_hit[c]) begin
               rd_hit = 1'b1;
               unique case (I_OD_SUB)
                  `CSD_SUB_US_EN:   rd_val = {31'h0, us_en_ff[c]};
                  `CSD_SUB_UC_EN:   rd_val = {31'h0, uc_en_ff[c]};
                  `CSD_SUB_VC_EN:   rd_val = {31'h0, vc_en_ff[c]};
                  `CSD_SUB_US_OFS:  rd_val = 32'(signed'(us_ofs_ff[c]));
                  `CSD_SUB_US_GAIN: rd_val = us_gain_ff[c];
                  `CSD_SUB_UC_OFS:  rd_val = 32'(signed'(uc_ofs_ff[c]));
                  `CSD_SUB_UC_GAIN: rd_val = {16'h0, uc_gain_ff[c]};
                  default:          rd_hit = 1'b0;
               endcase
            end
            if (vnd_hit[c] && I_OD_SUB == `CSD_SUB_VC_OFS)  begin rd_hit = 1'b1; rd_val = 32'(signed'(vc_ofs_ff[c])); end
            if (vnd_hit[c] && I_OD_SUB == `CSD_SUB_VC_GAIN) begin rd_hit = 1'b1; rd_val = {16'h0, vc_gain_ff[c]}; end
         end
      end
   end

   // Shadow fill level: ready comes from a flop and is still exact,
   // so a sender that obeys it never loses a sample to a full FIFO
   logic [3:0]  occ_ff;
   wire  [3:0]  nxt_occ = occ_ff + 4'(I_RAW_VALID && f_ready) - 4'(take);

   // Registered answers, one cycle after the strobe
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_OD_RDATA  <= 32'h0;
         O_OD_ACK    <= 1'b0;
         O_OD_ERR    <= 1'b0;
         O_RAW_READY <= 1'b0;
         occ_ff      <= 4'h0;
      end else begin
         O_OD_ACK    <= I_OD_RD || I_OD_WR;
         O_OD_ERR    <= I_OD_RD && !rd_hit;
         O_OD_RDATA  <= (I_OD_RD && rd_hit) ? rd_val : 32'h0;
         O_RAW_READY <= (nxt_occ != 4'(`CSD_FIFO_DEPTH));   // Room after this edge
         occ_ff      <= nxt_occ;
      end
   end
endmodule

// ==== csd_top_bench.sv ====
// Purpose: Self-checking bench for csd_top
// Assumes: 50 MHz clock, controller model on the object port
// Notes:   Gains are whole multiples of their shift unit so rounding never decides a result
`timescale 1ns/1ps
`include "csd_defines.svh"
module csd_top_bench;
   import csd_pkg::*;
   logic        clk, rst_n, raw_valid, raw_ready, raw_ch, od_wr, od_rd, od_ack, od_err, pv_valid, pv_ch;
   csd_sample_t raw_data, pv_data;
   csd_index_t  od_index;
   csd_sub_t    od_sub;
   csd_word_t   od_wdata, od_rdata, r;
   logic        e;
   logic [16:0] exp_pv;
   logic [16:0] exp_q[$];
   int          n_errors, checked, cycles, n;
   bit          vc_en[2], uc_en[2], us_en[2];
   int          uc_ofs[2], uc_gain[2], us_ofs[2], us_gain[2];
   csd_top csd_top_inst (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_RAW_VALID(raw_valid), .O_RAW_READY(raw_ready),
      .I_RAW_CH(raw_ch), .I_RAW_DATA(raw_data), .I_OD_WR(od_wr), .I_OD_RD(od_rd), .I_OD_INDEX(od_index),
      .I_OD_SUB(od_sub), .I_OD_WDATA(od_wdata), .O_OD_RDATA(od_rdata), .O_OD_ACK(od_ack), .O_OD_ERR(od_err),
      .O_PV_VALID(pv_valid), .O_PV_CH(pv_ch), .O_PV_DATA(pv_data));
   csd_od_master csd_od_master_inst (.i_clk(clk), .i_ack(od_ack), .i_err(od_err), .i_rdata(od_rdata),
      .o_wr(od_wr), .o_rd(od_rd), .o_index(od_index), .o_sub(od_sub), .o_wdata(od_wdata));
   // --------------------------------
   // Helpers
   // --------------------------------
   always #10 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   function automatic csd_index_t idx(input csd_index_t base, input logic ch);
      return base + (ch ? `CSD_IDX_CH_STEP : 16'h0000);
   endfunction
   function automatic csd_sample_t sat(input longint v);
      if (v > 32767) return 16'sh7fff;
      if (v < -32768) return 16'sh8000;
      return csd_sample_t'(v);
   endfunction
   // Expected result from the current settings; vendor offset is locked at zero
   function automatic logic [16:0] expect_pv(input logic ch, input csd_sample_t raw);
      longint y;
      y = raw;
      if (vc_en[ch]) y = sat((y * longint'(`CSD_VC_GAIN_RST)) >>> `CSD_CAL_SHIFT);
      if (uc_en[ch]) y = sat(((y - uc_ofs[ch]) * uc_gain[ch]) >>> `CSD_CAL_SHIFT);
      if (us_en[ch]) y = sat(((y * us_gain[ch]) >>> `CSD_SCL_SHIFT) + us_ofs[ch]);
      return {ch, sat(y)};
   endfunction
   task automatic wr(input csd_index_t i, input csd_sub_t s, input csd_word_t d);
      csd_od_master_inst.od_xfer(1'b1, i, s, d, $urandom_range(0, 3), r, e);
   endtask
   // Read and compare on the caller's behalf; the caller names the rule
   task automatic rd_chk(input csd_index_t i, input csd_sub_t s, input csd_word_t exp);
      csd_od_master_inst.od_xfer(1'b0, i, s, 32'h0, $urandom_range(0, 3), r, e);
      check({r[31:1], r[0] | e}, exp);
   endtask
   task automatic push(input logic ch, input csd_sample_t d);
      raw_valid = 1'b1;
      raw_ch    = ch;
      raw_data  = d;
      exp_q.push_back(expect_pv(ch, d));
      @(posedge clk);
      #1;
      raw_valid = 1'b0;
      raw_data  = ~d;
      @(posedge clk);   // Idle beat: a following call never retouches valid at once
      #1;
   endtask
   task automatic drain();
      n = 0;
      while (exp_q.size() > 0 && n < 200) begin
         @(posedge clk);
         n++;
      end
      #1;
      check(exp_q.size(), 0);
   endtask
   task automatic defaults();
      vc_en   = '{1'b1, 1'b1};
      uc_en   = '{1'b0, 1'b0};
      us_en   = '{1'b0, 1'b0};
      uc_ofs  = '{0, 0};
      us_ofs  = '{0, 0};
      uc_gain = '{65535, 65535};
      us_gain = '{65536, 65536};
   endtask
   // Scoreboard: every result matches the oldest expectation, read mid-cycle
   always @(negedge clk) begin
      if (pv_valid === 1'b1) begin
         exp_pv = exp_q.size() > 0 ? exp_q.pop_front() : 17'bx;
         check({15'h0, pv_ch, pv_data}, {15'h0, exp_pv});
      end
   end
   // Hang guard, ceiling well above the expected several hundred cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         $display("mismatch at %0t: run timed out", $time);
         final_report();
      end
   end
   // --------------------------------
   // Tests
   // --------------------------------
   initial begin
      {clk, rst_n, raw_valid, raw_ch, raw_data} = '0;
      void'($urandom(32'h00aeb5d9));
      defaults();
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      rd_chk(idx(`CSD_SET_IDX_BASE, 0), `CSD_SUB_VC_EN, 32'h1);
      rd_chk(idx(`CSD_SET_IDX_BASE, 0), `CSD_SUB_US_GAIN, `CSD_US_GAIN_RST);
      rd_chk(idx(`CSD_SET_IDX_BASE, 0), `CSD_SUB_UC_GAIN, 32'h0000ffff);
      rd_chk(idx(`CSD_SET_IDX_BASE, 1), `CSD_SUB_UC_OFS, 32'h0);
      rd_chk(`CSD_RESTORE_IDX, `CSD_RESTORE_SUB_CNT, 32'h1);
      rd_chk(16'h7777, 8'h01, 32'h1);
      $display("test defaults done");
      for (int k = 0; k < 6; k++) begin
         push(k[0], csd_sample_t'($urandom));
         drain();
         rd_chk(idx(`CSD_RAW_IDX_BASE, k[0]), `CSD_SUB_RAW, 32'(~raw_data));
      end
      $display("test pass-through done");
      wr(idx(`CSD_VEND_IDX_BASE, 0), `CSD_SUB_VC_OFS, 32'h100);
      rd_chk(idx(`CSD_VEND_IDX_BASE, 0), `CSD_SUB_VC_OFS, 32'h0);
      push(1'b0, 16'sh1234);
      drain();
      $display("test vendor lock done");
      for (int t = 0; t < 14; t++) begin
         logic ch;
         ch          = t[0];
         vc_en[ch]   = $urandom_range(0, 1);
         uc_en[ch]   = $urandom_range(0, 1);
         us_en[ch]   = t > 1 ? $urandom_range(0, 1) : 1'b1;
         uc_ofs[ch]  = int'($urandom_range(0, 2000)) - 1000;
         uc_gain[ch] = int'($urandom_range(0, 3)) << 14;
         us_gain[ch] = (int'($urandom_range(0, 4)) - 2) * 65536;
         us_ofs[ch]  = int'($urandom_range(0, 4000)) - 2000;
         wr(idx(`CSD_SET_IDX_BASE, ch), `CSD_SUB_VC_EN, 32'(vc_en[ch]));
         wr(idx(`CSD_SET_IDX_BASE, ch), `CSD_SUB_UC_EN, 32'(uc_en[ch]));
         wr(idx(`CSD_SET_IDX_BASE, ch), `CSD_SUB_US_EN, 32'(us_en[ch]));
         wr(idx(`CSD_SET_IDX_BASE, ch), `CSD_SUB_UC_OFS, 32'(uc_ofs[ch]));
         wr(idx(`CSD_SET_IDX_BASE, ch), `CSD_SUB_UC_GAIN, 32'(uc_gain[ch]));
         wr(idx(`CSD_SET_IDX_BASE, ch), `CSD_SUB_US_GAIN, 32'(us_gain[ch]));
         wr(idx(`CSD_SET_IDX_BASE, ch), `CSD_SUB_US_OFS, 32'(us_ofs[ch]));
         push(ch, t < 2 ? 16'sh7fff : csd_sample_t'($urandom));
         push(ch, t < 2 ? 16'sh8000 : csd_sample_t'($urandom));
         drain();
      end
      $display("test random settings done");
      n = 0;
      while (raw_ready === 1'b1 && n < 40) begin
         push(n[0], csd_sample_t'($urandom));
         n++;
      end
      check(32'(n >= `CSD_FIFO_DEPTH), 32'h1);
      drain();
      $display("test burst done");
      wr(`CSD_RESTORE_IDX, `CSD_RESTORE_SUB_KEY, `CSD_RESTORE_KEY + 32'h1);
      rd_chk(idx(`CSD_SET_IDX_BASE, 1), `CSD_SUB_US_EN, 32'(us_en[1]));
      wr(`CSD_RESTORE_IDX, `CSD_RESTORE_SUB_KEY, `CSD_RESTORE_KEY);
      defaults();
      rd_chk(idx(`CSD_SET_IDX_BASE, 1), `CSD_SUB_US_GAIN, `CSD_US_GAIN_RST);
      rd_chk(idx(`CSD_SET_IDX_BASE, 1), `CSD_SUB_US_EN, 32'h0);
      rd_chk(`CSD_RESTORE_IDX, `CSD_RESTORE_SUB_KEY, 32'h0);
      push(1'b1, 16'sh4321);
      drain();
      $display("test restore done");
      final_report();
   end
endmodule

// ==== csd_top_monitor.sv ====
// Purpose: Port-level assertions for csd_top
// Assumes: Raw samples are pushed only while O_RAW_READY is high
// Notes:   Default reads are judged only until the first object write
`timescale 1ns/1ps
`include "csd_defines.svh"
module csd_top_monitor (
   input wire logic                 I_REF_CLK,
   input wire logic                 I_RST_N,
   input wire logic                 I_RAW_VALID,
   input wire logic                 O_RAW_READY,
   input wire logic                 I_RAW_CH,
   input wire csd_pkg::csd_sample_t I_RAW_DATA,
   input wire logic                 I_OD_WR,
   input wire logic                 I_OD_RD,
   input wire csd_pkg::csd_index_t  I_OD_INDEX,
   input wire csd_pkg::csd_sub_t    I_OD_SUB,
   input wire csd_pkg::csd_word_t   I_OD_WDATA,
   input wire csd_pkg::csd_word_t   O_OD_RDATA,
   input wire logic                 O_OD_ACK,
   input wire logic                 O_OD_ERR,
   input wire logic                 O_PV_VALID,
   input wire logic                 O_PV_CH,
   input wire csd_pkg::csd_sample_t O_PV_DATA
);
   import csd_pkg::*;
   // --------------------------------
   // Helper state
   // --------------------------------
   logic        push;
   logic        rd0;
   logic        touched_ff;
   logic [7:0]  since_ff;
   csd_sample_t last_ff;
   assign push = I_RAW_VALID && O_RAW_READY;
   assign rd0  = I_OD_RD && !touched_ff && I_OD_INDEX == `CSD_SET_IDX_BASE;
   // Age saturates so a long quiet spell never wraps into a false match
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         touched_ff <= 1'b0;
         since_ff   <= 8'h00;
         last_ff    <= 16'sh0000;
      end else begin
         touched_ff <= touched_ff | I_OD_WR;
         since_ff   <= push ? 8'h00 : since_ff + {7'h00, since_ff != 8'hff};
         last_ff    <= push ? I_RAW_DATA : last_ff;
      end
   end
   // --------------------------------
   // Assertions
   // --------------------------------
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_N);
   pv_follows_a: assert property (push |-> ##[1:60] O_PV_VALID)
      else $error("raw sample gave no result");
   pv_caused_a: assert property (O_PV_VALID |-> since_ff < 8'd60)
      else $error("result without a recent sample");
   pv_spacing_a: assert property (O_PV_VALID |=> !O_PV_VALID [*3])
      else $error("results closer than four cycles");
   pv_hold_a: assert property (!O_PV_VALID |-> $stable(O_PV_DATA) && $stable(O_PV_CH))
      else $error("result changed without valid");
   raw_pass_a: assert property (O_PV_VALID && !touched_ff && since_ff < 8'd8 |-> O_PV_DATA == last_ff)
      else $error("default chain altered the sample");
   restore_cnt_a: assert property (I_OD_RD && I_OD_INDEX == `CSD_RESTORE_IDX && I_OD_SUB == `CSD_RESTORE_SUB_CNT
      |=> O_OD_ACK && O_OD_RDATA == 32'h00000001) else $error("restore count wrong");
   vc_en_dflt_a: assert property (rd0 && I_OD_SUB == `CSD_SUB_VC_EN |=> O_OD_RDATA == 32'h00000001)
      else $error("vendor enable not set by default");
   us_gain_dflt_a: assert property (rd0 && I_OD_SUB == `CSD_SUB_US_GAIN |=> O_OD_RDATA == `CSD_US_GAIN_RST)
      else $error("scaling gain default wrong");
   uc_gain_dflt_a: assert property (rd0 && I_OD_SUB == `CSD_SUB_UC_GAIN |=> O_OD_RDATA[15:0] == 16'hffff)
      else $error("calibration gain default wrong");
   cover property (O_PV_VALID && O_PV_DATA == 16'sh7fff);
   cover property (I_OD_WR && I_OD_WDATA == `CSD_RESTORE_KEY);
   cover property (O_OD_ERR);
endmodule
bind csd_top csd_top_monitor csd_top_monitor_inst (.I_REF_CLK, .I_RST_N, .I_RAW_VALID, .O_RAW_READY, .I_RAW_CH,
   .I_RAW_DATA, .I_OD_WR, .I_OD_RD, .I_OD_INDEX, .I_OD_SUB, .I_OD_WDATA, .O_OD_RDATA, .O_OD_ACK, .O_OD_ERR,
   .O_PV_VALID, .O_PV_CH, .O_PV_DATA);
